/* File: rtl/cxs_core.sv */
`timescale 1ns/1ps
module cxs_core
  import cxs_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  input  wire logic          i_enable,
  input  wire logic          i_ext_cfg,       // configuration bit, erased = 1
  input  wire logic          i_valid,         // instruction word present
  input  wire logic [15:0]   i_instr,
  input  wire logic          i_next_two_word, // fetched next word is a two-word instr
  input  wire logic [7:0]    i_file_rdata,    // operand read for current address
  input  wire logic [3:0]    i_bank_sel,      // bank select register
  input  wire logic [7:0]    i_table_latch,
  output cxs_file_req_t      o_file_req,
  output logic [11:0]        o_file_addr,     // registered operand address view
  output logic [7:0]         o_accum,
  output cxs_flags_t         o_flags,
  output logic               o_flags_we,
  output logic               o_busy,          // core inserts forced no-ops
  output logic               o_flush,         // discard fetched instruction
  output logic               o_return,        // pop return address
  output logic [20:0]        o_table_pointer,
  output logic [11:0]        o_ptr0,
  output logic [11:0]        o_ptr1,
  output logic [11:0]        o_ptr2,
  output logic [7:0]         o_hold [HOLD_REGS],
  output logic               o_hold_we,
  output logic [2:0]         o_hold_idx,
  output logic               o_byte_hi        // table byte lane select
);
  // the address forming logic is written for a 12-bit data space only
  if (ADDR_W != 12) begin : g_bad_addr_w
    $error("cxs_core serves a 12-bit data address only");
  end

  // reset release through two flops
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // operand address: access bank, banked, or indexed off the third pointer
  function automatic logic [11:0] form_addr(input logic a, input logic [7:0] f, input logic [3:0] bank,
                                            input logic ext, input logic [11:0] p2);
    if (a) form_addr = {bank, f};
    else if (ext && f <= 8'(ACCESS_SPLIT)) form_addr = p2 + {4'h0, f};
    else if (f <= 8'(ACCESS_SPLIT)) form_addr = {4'h0, f};
    else form_addr = {4'hf, f};
  endfunction

  function automatic cxs_flags_t nz(input logic [7:0] r);
    nz.n = r[7];
    nz.z = (r == 8'h00);
  endfunction

  // decode
  logic is_tst, is_xorl, is_xorf, is_tw, is_addp, is_subp;
  logic ext_on;
  always_comb begin
    ext_on  = i_ext_cfg;
    is_tst  = i_instr[15:9] == 7'b0110011;
    is_xorl = i_instr[15:8] == 8'h0a;
    is_xorf = i_instr[15:10] == 6'b000110;
    is_tw   = i_instr[15:2] == 14'h0003;
    is_addp = ext_on && i_instr[15:8] == 8'he8;
    is_subp = ext_on && i_instr[15:8] == 8'he9;
  end

  cxs_state_t    state, next_state;
  logic [7:0]    accum, next_accum;
  cxs_flags_t    flags, next_flags;
  logic          flags_we, next_flags_we;
  cxs_file_req_t req, next_req;
  logic [11:0]   faddr, next_faddr;
  logic          flush, next_flush;
  logic          ret, next_ret;
  logic [20:0]   tptr, next_tptr;
  logic [11:0]   ptr [3];
  logic [11:0]   next_ptr [3];
  logic [7:0]    hold [HOLD_REGS];
  logic [7:0]    next_hold [HOLD_REGS];
  logic          hold_we, next_hold_we;
  logic [2:0]    hold_idx, next_hold_idx;
  logic          byte_hi, next_byte_hi;
  logic          busy, next_busy;         // own flop so the output is not a decode of state

  // next-state for the whole execute path
  always_comb begin
    logic [11:0] ea;
    logic [7:0]  res;
    logic [20:0] tw_ptr;
    logic [11:0] lit;
    ea = form_addr(i_instr[8], i_instr[7:0], i_bank_sel, ext_on, ptr[2]);
    res = 8'h00;
    tw_ptr = tptr;
    lit = {6'h00, i_instr[5:0]};
    next_state    = state;
    next_accum    = accum;
    next_flags    = flags;
    next_flags_we = 1'b0;
    next_req      = '0;
    next_faddr    = faddr;
    next_flush    = 1'b0;
    next_ret      = 1'b0;
    next_tptr     = tptr;
    next_ptr      = ptr;
    next_hold     = hold;
    next_hold_we  = 1'b0;
    next_hold_idx = hold_idx;
    next_byte_hi  = tptr[0];
    unique case (state)
      CXS_EXEC: begin
        if (i_valid) begin
          if (is_tst) begin
            next_faddr = ea;
            if (i_file_rdata == 8'h00) begin
              next_flush = 1'b1;
              next_state = i_next_two_word ? CXS_NOP2 : CXS_NOP1;
            end
          end else if (is_xorl) begin
            res = accum ^ i_instr[7:0];
            next_accum    = res;
            next_flags    = nz(res);
            next_flags_we = 1'b1;
          end else if (is_xorf) begin
            next_faddr = ea;
            res = accum ^ i_file_rdata;
            next_flags    = nz(res);
            next_flags_we = 1'b1;
            if (i_instr[9]) begin
              next_req.wr    = 1'b1;
              next_req.addr  = ea;
              next_req.wdata = res;
            end else begin
              next_accum = res;
            end
          end else if (is_tw) begin
            if (i_instr[1:0] == TW_PREINC) tw_ptr = tptr + 21'h000001;
            next_hold[tw_ptr[2:0]] = i_table_latch;
            next_hold_idx = tw_ptr[2:0];
            next_hold_we  = 1'b1;
            next_byte_hi  = tw_ptr[0];
            unique case (i_instr[1:0])
              TW_NONE:    next_tptr = tptr;
              TW_POSTINC: next_tptr = tptr + 21'h000001;
              TW_POSTDEC: next_tptr = tptr - 21'h000001;
              TW_PREINC:  next_tptr = tw_ptr;
            endcase
            next_state = CXS_NOP1;
          end else if (is_addp || is_subp) begin
            if (i_instr[7:6] == 2'b11) begin
              next_ptr[2] = is_addp ? ptr[2] + lit : ptr[2] - lit;
              next_ret   = 1'b1;
              next_flush = 1'b1;
              next_state = CXS_RET;
            end else begin
              next_ptr[i_instr[7:6]] = is_addp ? ptr[i_instr[7:6]] + lit : ptr[i_instr[7:6]] - lit;
            end
          end
        end
      end
      CXS_NOP2: next_state = CXS_NOP1;
      CXS_NOP1: next_state = CXS_EXEC;
      CXS_RET:  next_state = CXS_EXEC;
      default:  next_state = CXS_EXEC;
    endcase
    next_req.rd = i_valid && state == CXS_EXEC && (is_tst || is_xorf);
    if (next_req.rd && !next_req.wr) next_req.addr = ea;
    next_busy = next_state != CXS_EXEC;
  end

  // state registers, frozen while the enable is low
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= CXS_EXEC;
      accum    <= ACC_RESET;
      flags    <= '0;
      flags_we <= 1'b0;
      req      <= '0;
      faddr    <= PTR_RESET;
      flush    <= 1'b0;
      ret      <= 1'b0;
      tptr     <= TPTR_RESET;
      ptr      <= '{default: PTR_RESET};
      hold     <= '{default: HOLD_RESET};
      hold_we  <= 1'b0;
      hold_idx <= 3'h0;
      byte_hi  <= 1'b0;
      busy     <= 1'b0;
    end else if (i_enable) begin
      state    <= next_state;
      accum    <= next_accum;
      flags    <= next_flags;
      flags_we <= next_flags_we;
      req      <= next_req;
      faddr    <= next_faddr;
      flush    <= next_flush;
      ret      <= next_ret;
      tptr     <= next_tptr;
      ptr      <= next_ptr;
      hold     <= next_hold;
      hold_we  <= next_hold_we;
      hold_idx <= next_hold_idx;
      byte_hi  <= next_byte_hi;
      busy     <= next_busy;
    end
  end

  // outputs straight from flops
  assign o_file_req      = req;
  assign o_file_addr     = faddr;
  assign o_accum         = accum;
  assign o_flags         = flags;
  assign o_flags_we      = flags_we;
  assign o_busy          = busy;
  assign o_flush         = flush;
  assign o_return        = ret;
  assign o_table_pointer = tptr;
  assign o_ptr0          = ptr[0];
  assign o_ptr1          = ptr[1];
  assign o_ptr2          = ptr[2];
  assign o_hold          = hold;
  assign o_hold_we       = hold_we;
  assign o_hold_idx      = hold_idx;
  assign o_byte_hi       = byte_hi;
endmodule // cxs_core

/* File: rtl/cxs_pkg.sv */
// Notes on behaviour
// - test-file-skip-zero on a zero operand discards the fetched instruction, two cycles.
// - a skip over a two-word instruction makes the test take three cycles.
// - access-select zero addresses the access bank.
// - access-select one forms the address with the bank select register.
// - access-select zero, extensions on, operand 95 or below: indexed literal offset.
// - xor-literal: accumulator xor 8-bit immediate into accumulator, n and z updated.
// - xor-file: accumulator xor file register, n and z updated, one cycle.
// - xor-file destination bit: zero to accumulator, one back to file register.
// - standard set plus eight optional extended literal instructions; the core decodes only two (add and subtract literal to pointer).
// - extensions are active when the configuration storage is erased.
// - a configuration bit set at programming enables or disables the extensions.
// - extended instructions are literal ops on or through a file select pointer.
// - add and subtract literal to pointer have third-pointer auto-return variants.
// - table write copies the table latch into one of eight holding registers.
// - table write pointer modes: none, post-inc, post-dec, pre-inc from opcode bits.
// - table pointer bit zero selects low or high byte of the program word.
package cxs_pkg;
  localparam int unsigned  ACCESS_SPLIT   = 8'h5f;   // access bank split / indexed limit
  localparam logic [7:0]   ACC_RESET      = 8'h00;
  localparam logic [20:0]  TPTR_RESET     = 21'h000000;
  localparam logic [11:0]  PTR_RESET      = 12'h000;
  localparam logic [3:0]   BANK_RESET     = 4'h0;
  localparam logic [7:0]   HOLD_RESET     = 8'hff;   // holding registers start erased
  localparam logic         EXT_ERASED     = 1'b1;    // erased configuration cell reads one
  localparam logic [1:0]   TW_NONE        = 2'h0;
  localparam logic [1:0]   TW_POSTINC     = 2'h1;
  localparam logic [1:0]   TW_POSTDEC     = 2'h2;
  localparam logic [1:0]   TW_PREINC      = 2'h3;
  localparam int unsigned  HOLD_REGS      = 8;

  typedef enum logic [3:0] {
    CXS_EXEC  = 4'b0001,
    CXS_NOP1  = 4'b0010,
    CXS_NOP2  = 4'b0100,
    CXS_RET   = 4'b1000
  } cxs_state_t;

  // file register access request toward the data memory
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } cxs_file_req_t;

  // alu flags
  typedef struct packed {
    logic n;
    logic z;
  } cxs_flags_t;
endpackage

/* File: bench/cxs_core_asserts.sv */
`timescale 1ns/1ps
module cxs_core_chk
  import cxs_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_enable,
  input wire logic        i_ext_cfg,
  input wire logic        i_valid,
  input wire logic [15:0] i_instr,
  input wire logic        i_next_two_word,
  input wire logic [7:0]  i_file_rdata,
  input wire logic [3:0]  i_bank_sel,
  input cxs_file_req_t    o_file_req,
  input wire logic [11:0] o_file_addr,
  input wire logic [7:0]  o_accum,
  input cxs_flags_t       o_flags,
  input wire logic        o_flags_we,
  input wire logic        o_busy,
  input wire logic        o_flush,
  input wire logic        o_return,
  input wire logic [20:0] o_table_pointer,
  input wire logic [11:0] o_ptr2,
  input wire logic        o_hold_we,
  input wire logic [2:0]  o_hold_idx
);
  // decoded takes; only accepted cycles arm the checks
  wire tk  = i_enable && i_valid && !o_busy;
  wire tst = tk && i_instr[15:9] == 7'h33;
  wire xwf = tk && i_instr[15:10] == 6'h06;
  wire xlw = tk && i_instr[15:8] == 8'h0a;
  wire fop = tst || xwf;
  wire zr  = i_file_rdata == 8'h00;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  xlw_acc_a: assert property (xlw |=> o_flags_we &&
    o_accum == ($past(o_accum) ^ $past(i_instr[7:0]))) else $error("xor literal result wrong");
  xlw_flag_a: assert property (xlw |=> o_flags.z == (o_accum == 8'h00) && o_flags.n == o_accum[7])
    else $error("xor flags wrong");
  xwf_dest_a: assert property (xwf |=> o_flags_we && o_file_req.wr == $past(i_instr[9]) &&
    (o_file_req.wr ? o_file_req.wdata : o_accum) == ($past(o_accum) ^ $past(i_file_rdata))) else $error("xor file wrong");
  bank_addr_a: assert property (fop && i_instr[8] |=>
    o_file_addr == {$past(i_bank_sel), $past(i_instr[7:0])}) else $error("banked address wrong");
  access_a: assert property (fop && !i_instr[8] && i_instr[7:0] > 8'h5f |=>
    o_file_addr == {4'hf, $past(i_instr[7:0])}) else $error("access bank address wrong");
  access_low_a: assert property (fop && !i_instr[8] && !i_ext_cfg && i_instr[7:0] <= 8'h5f |=>
    o_file_addr == {4'h0, $past(i_instr[7:0])}) else $error("low access bank address wrong");
  indexed_a: assert property (fop && !i_instr[8] && i_ext_cfg && i_instr[7:0] <= 8'h5f |=>
    o_file_addr == $past(o_ptr2) + $past(i_instr[7:0])) else $error("indexed address wrong");
  skip_one_a: assert property (tst && zr && !i_next_two_word |=> o_flush && o_busy ##1 !o_busy)
    else $error("skip length wrong");
  skip_two_a: assert property (tst && zr && i_next_two_word |=> o_flush && o_busy ##1 o_busy ##1 !o_busy)
    else $error("two word skip length wrong");
  noskip_a: assert property (tst && !zr |=> !o_busy && !o_flush && !o_flags_we)
    else $error("test without skip wrong");
  auto_ret_a: assert property (tk && i_ext_cfg && i_instr[15:9] == 7'h74 && i_instr[7:6] == 2'b11 |=> o_return)
    else $error("auto return missing");
  tw_inc_a: assert property (tk && i_instr == 16'h000d |=> o_hold_we &&
    o_hold_idx == $past(o_table_pointer[2:0]) && o_table_pointer == $past(o_table_pointer) + 21'h1)
    else $error("table write post increment wrong");
  cover property (tst && zr && i_next_two_word);
  cover property (o_return);
  cover property (o_hold_we);
endmodule // cxs_core_chk

bind cxs_core cxs_core_chk u_chk (.i_clock, .i_rst_n, .i_enable, .i_ext_cfg, .i_valid, .i_instr,
  .i_next_two_word, .i_file_rdata, .i_bank_sel, .o_file_req, .o_file_addr, .o_accum, .o_flags,
  .o_flags_we, .o_busy, .o_flush, .o_return, .o_table_pointer, .o_ptr2, .o_hold_we, .o_hold_idx);

/* File: bench/test_cxs_core.sv */
`timescale 1ns/1ps
module test_cxs_core;
  import cxs_pkg::*;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_enable = 1'b1, i_ext_cfg = EXT_ERASED, i_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic i_next_two_word = 1'b0;
  logic [7:0] i_file_rdata = 8'h00, i_table_latch = 8'h00;
  logic [3:0] i_bank_sel = 4'h0;
  cxs_file_req_t o_file_req;
  cxs_flags_t o_flags;
  logic [11:0] o_file_addr, o_ptr0, o_ptr1, o_ptr2;
  logic [7:0] o_accum;
  logic [7:0] o_hold [HOLD_REGS];
  logic [20:0] o_table_pointer;
  logic [2:0] o_hold_idx;
  logic o_flags_we, o_busy, o_flush, o_return, o_hold_we, o_byte_hi;
  int fail_count = 0, compares = 0;

  cxs_core u_cxs_core (.i_clock, .i_rst_n, .i_enable, .i_ext_cfg, .i_valid, .i_instr, .i_next_two_word,
    .i_file_rdata, .i_bank_sel, .i_table_latch, .o_file_req, .o_file_addr, .o_accum, .o_flags, .o_flags_we,
    .o_busy, .o_flush, .o_return, .o_table_pointer, .o_ptr0, .o_ptr1, .o_ptr2, .o_hold, .o_hold_we,
    .o_hold_idx, .o_byte_hi);

  always #20 i_clock = ~i_clock;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // one idle cycle first, so valid is never lowered and raised in one step
  task automatic op(input logic [15:0] ins, input logic [7:0] rd, input logic two);
    int n;
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_busy !== 1'b0 && n < 8);
    i_instr = ins;
    i_file_rdata = rd;
    i_next_two_word = two;
    i_valid = 1'b1;
    @(negedge i_clock);
    i_valid = 1'b0;
  endtask

  task automatic t_xor_lit;
    op(16'h0ab5, 8'h00, 1'b0);
    chk("acc", 32'(8'hb5), 32'(o_accum));
    chk("flags", 32'(3'b110), 32'({o_flags_we, o_flags}));
    op(16'h0aaf, 8'h00, 1'b0);
    chk("acc", 32'(8'h1a), 32'(o_accum));
    op(16'h0a1a, 8'h00, 1'b0);
    chk("flags", 32'(3'b101), 32'({o_flags_we, o_flags}));
  endtask

  // request word is {rd, wr, addr, wdata}
  task automatic t_xor_file;
    i_bank_sel = 4'h3;
    op(16'h1b20, 8'haf, 1'b0);
    chk("wr", 32'({1'b1, 1'b1, 12'h320, 8'haf}), 32'(o_file_req));
    chk("acc", 32'(8'h00), 32'(o_accum));
    op(16'h1920, 8'hb5, 1'b0);
    chk("rd", 32'({1'b1, 1'b0, 12'h320, 8'h00}), 32'(o_file_req));
    chk("acc", 32'({1'b0, 8'hb5}), 32'({o_file_req.wr, o_accum}));
    op(16'h1880, 8'h01, 1'b0);
    chk("addr", 32'(12'hf80), 32'(o_file_addr));
  endtask

  task automatic t_ext;
    op(16'he8e3, 8'h00, 1'b0);
    chk("ret", 32'({1'b1, 12'h023}), 32'({o_return, o_ptr2}));
    op(16'he9c1, 8'h00, 1'b0);
    chk("ret", 32'({1'b1, 12'h022}), 32'({o_return, o_ptr2}));
    op(16'he805, 8'h00, 1'b0);
    chk("ptr0", 32'({1'b0, 12'h005}), 32'({o_return, o_ptr0}));
    op(16'he947, 8'h00, 1'b0);
    chk("ptr1", 32'({1'b0, 12'hff9}), 32'({o_return, o_ptr1}));
    op(16'h1810, 8'h00, 1'b0);
    chk("addr", 32'(12'h032), 32'(o_file_addr));
    i_ext_cfg = 1'b0;
    op(16'he8e3, 8'h00, 1'b0);
    chk("ret", 32'({1'b0, 12'h022}), 32'({o_return, o_ptr2}));
    op(16'h1810, 8'h00, 1'b0);
    chk("addr", 32'(12'h010), 32'(o_file_addr));
    i_ext_cfg = EXT_ERASED;
  endtask

  task automatic t_skip;
    op(16'h6720, 8'h00, 1'b0);
    chk("skip", 32'(3'b110), 32'({o_flush, o_busy, o_flags_we}));
    @(negedge i_clock);
    chk("busy", 32'(1'b0), 32'(o_busy));
    op(16'h6720, 8'h00, 1'b1);
    @(negedge i_clock);
    chk("busy", 32'(1'b1), 32'(o_busy));
    @(negedge i_clock);
    chk("busy", 32'(1'b0), 32'(o_busy));
    op(16'h6720, 8'h05, 1'b0);
    chk("noskip", 32'(3'b000), 32'({o_flush, o_busy, o_flags_we}));
  endtask

  // pointer starts at zero after reset; modes walk it 0,1,2,1,1
  task automatic t_table;
    i_table_latch = 8'h55;
    op(16'h000d, 8'h00, 1'b0);
    chk("tw", 32'({1'b1, 8'h55, 21'h1}), 32'({o_hold_we, o_hold[0], o_table_pointer}));
    i_table_latch = 8'h34;
    op(16'h000f, 8'h00, 1'b0);
    chk("tw", 32'({3'h2, 8'h34, 21'h2}), 32'({o_hold_idx, o_hold[2], o_table_pointer}));
    i_table_latch = 8'h66;
    op(16'h000e, 8'h00, 1'b0);
    chk("tw", 32'({8'h66, 21'h1}), 32'({o_hold[2], o_table_pointer}));
    i_table_latch = 8'h77;
    op(16'h000c, 8'h00, 1'b0);
    chk("tw", 32'({1'b1, 8'h77, 21'h1}), 32'({o_byte_hi, o_hold[1], o_table_pointer}));
  endtask

  task automatic report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under 200 cycles
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clock);
    t_xor_lit();
    t_xor_file();
    t_ext();
    t_skip();
    t_table();
    report_and_stop();
  end
endmodule // test_cxs_core
